/* File: bbc_core.sv */
// core-side end: boot programming, watchdog service, user accesses
// assumes the device answers each request with one ack pulse
module bbc_core
   import bbc_pkg::*;
(
   // clock and cold reset
   input wire logic clk,
   input wire logic rst_b,
   // device side
   bbc_link_if.core link,
   // user command port
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [31:0] cmd_addr,
   input wire logic [31:0] cmd_wdata,
   output logic cmd_ready,
   // user result port
   output logic res_valid,
   output logic [31:0] res_data,
   output logic res_err
);
   import bbc_pkg::*;

   typedef enum logic [2:0]
   {
      BBC_BOOT = 3'b001,
      BBC_READY = 3'b010,
      BBC_WAIT = 3'b100
   } bbc_cst_t;

   typedef struct packed
   {
      bbc_cst_t st;
      logic [2:0] step;
      logic user;
      logic [15:0] kick;
      logic req;
      logic wr;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic ready;
      logic res_valid;
      logic [31:0] res_data;
      logic res_err;
   } bbc_cstate_t;

   bbc_cstate_t s_r;
   bbc_cstate_t s_nxt;

   always_comb
   begin
      logic kick_due;
      kick_due = (s_r.kick >= BBC_KICK_CYC);
      s_nxt = s_r;
      s_nxt.res_valid = 1'b0;
      if (!kick_due)
         s_nxt.kick = s_r.kick + 16'h1;
      unique case (s_r.st)
         BBC_BOOT:
         begin
            s_nxt.req = 1'b1;
            s_nxt.wr = 1'b1;
            s_nxt.user = 1'b0;
            s_nxt.st = BBC_WAIT;
            unique case (s_r.step)
               3'h0:
               begin
                  // [RQ14] register region 32-bit first
                  s_nxt.addr = BBC_WIDTH_ADDR;
                  s_nxt.wdata = BBC_BOOT_WIDTHS;
               end
               3'h1:
               begin
                  // [RQ19] [RQ22] one turnaround clock, never zero
                  s_nxt.addr = BBC_TURN_ADDR;
                  s_nxt.wdata = BBC_BOOT_TURNS;
               end
               3'h2:
               begin
                  s_nxt.addr = BBC_CPU_LIM_ADDR;
                  s_nxt.wdata = {16'h0, BBC_BOOT_CPU_LIM};
               end
               3'h3:
               begin
                  // [RQ12] peripheral limit one above
                  s_nxt.addr = BBC_IP_LIM_ADDR;
                  s_nxt.wdata = {16'h0, BBC_BOOT_CPU_LIM + 16'h1};
               end
               default:
               begin
                  s_nxt.addr = BBC_CTRL_ADDR;
                  s_nxt.wdata = {29'h0, BBC_CTRL_ALL};
               end
            endcase
         end
         BBC_READY:
         begin
            if (cmd_valid && s_r.ready)
            begin
               s_nxt.req = 1'b1;
               s_nxt.wr = cmd_write;
               s_nxt.addr = cmd_addr;
               s_nxt.wdata = cmd_wdata;
               s_nxt.user = 1'b1;
               s_nxt.st = BBC_WAIT;
            end
            // [RQ3] periodic zero write to watchdog
            else if (kick_due)
            begin
               s_nxt.req = 1'b1;
               s_nxt.wr = 1'b1;
               s_nxt.addr = BBC_WDOG_ADDR;
               s_nxt.wdata = 32'h0;
               s_nxt.user = 1'b0;
               s_nxt.kick = 16'h0;
               s_nxt.st = BBC_WAIT;
            end
         end
         BBC_WAIT:
         begin
            if (link.ack)
            begin
               s_nxt.req = 1'b0;
               if (s_r.user)
               begin
                  s_nxt.res_valid = 1'b1;
                  s_nxt.res_data = link.rdata;
                  s_nxt.res_err = link.berr;
               end
               if (s_r.step < 3'h5)
               begin
                  s_nxt.step = s_r.step + 3'h1;
                  s_nxt.st = (s_r.step == 3'h4) ? BBC_READY : BBC_BOOT;
               end
               else
                  s_nxt.st = BBC_READY;
            end
         end
      endcase
      // ready only when the next cycle can take a command
      s_nxt.ready = (s_nxt.st == BBC_READY) && !(s_nxt.kick >= BBC_KICK_CYC);
      // warm reset restarts boot programming; straps are not ours
      if (!link.warm_rst_b)
      begin
         s_nxt = '0;
         s_nxt.st = BBC_BOOT;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s_r <= '0;
         s_r.st <= BBC_BOOT;
      end
      else
         s_r <= s_nxt;
   end

   assign link.req = s_r.req;
   assign link.wr = s_r.wr;
   assign link.addr = s_r.addr;
   assign link.wdata = s_r.wdata;
   assign cmd_ready = s_r.ready;
   assign res_valid = s_r.res_valid;
   assign res_data = s_r.res_data;
   assign res_err = s_r.res_err;
endmodule : bbc_core

/* File: bbc_dev.sv */
// bus-control device: port widths, read turnaround, time-outs, watchdog
// assumes the core holds req with its fields until one cycle after ack
// Overview of operation
// [RQ1] watchdog rollover pulses warm reset to core
// [RQ2] warm reset keeps latched boot settings
// [RQ3] software writes zero to watchdog count
// [RQ4] standard boot: watchdog enabled, software can disable
// [RQ5] status bit shows watchdog caused reset
// [RQ6] host-bus boot: watchdog disabled at reset
// [RQ7] two 16-bit counters, limits, enable bits
// [RQ8] time-out returns error plus ack, interrupt
// [RQ9] time-out latches transfer address
// [RQ10] core time-out also flags peripheral time-out
// [RQ11] peripheral timer counts only peripheral hold
// [RQ12] software sets peripheral limit one above
// [RQ13] widths reset to boot width, then programmable
// [RQ14] boot code sets register region 32-bit
// [RQ15] kernel 512MB split into eight 64MB
// [RQ16] remaining space split into seven 512MB
// [RQ17] turnaround fields reset to three cycles
// [RQ18] after read wait region turnaround clocks
// [RQ19] software avoids zero turnaround setting
// [RQ20] fault address register is read-only
// [RQ21] no turnaround after descriptor burst read
// [RQ22] software sets register region turnaround nonzero
// [RQ23] counters clear at start, count, compare
module bbc_dev
   import bbc_pkg::*;
#(
   parameter int WDOG_BITS = bbc_pkg::BBC_WDOG_BITS
)
(
   // clock and cold reset
   input wire logic clk,
   input wire logic rst_b,
   // core side
   bbc_link_if.dev link,
   // boot straps
   input wire bbc_pkg::bbc_width_t boot_width,
   input wire logic host_boot,
   // external memory side
   output logic mem_start,
   output logic [31:0] mem_addr,
   output logic mem_write,
   output logic [31:0] mem_wdata,
   output bbc_pkg::bbc_width_t mem_width,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   // peripheral bus and dma
   input wire logic dma_desc_read,
   input wire logic ip_hold,
   output logic bus_irq
);
   import bbc_pkg::*;

   typedef enum logic [2:0]
   {
      BBC_IDLE = 3'b001,
      BBC_MEM = 3'b010,
      BBC_RESP = 3'b100
   } bbc_dst_t;

   typedef struct packed
   {
      bbc_dst_t st;
      logic booted;
      logic ack;
      logic berr;
      logic [31:0] rdata;
      logic warm_b;
      logic [2:0] warm_cnt;
      logic mem_start;
      logic [31:0] mem_addr;
      logic mem_write;
      logic [31:0] mem_wdata;
      bbc_width_t mem_width;
      logic [1:0] mem_turn;
      logic irq;
      logic [31:0] width;
      logic [31:0] turn;
      logic [31:0] fault;
      logic [2:0] ctrl;
      logic [15:0] cpu_lim;
      logic [15:0] ip_lim;
      logic [2:0] stat;
      logic [WDOG_BITS-1:0] wd_cnt;
      logic [15:0] cpu_cnt;
      logic [15:0] ip_cnt;
      logic [1:0] gap;
   } bbc_dstate_t;

   bbc_dstate_t s_r;
   bbc_dstate_t s_nxt;

   always_comb
   begin
      logic wd_wr;
      logic [3:0] rg;
      logic [31:0] rd;
      wd_wr = 1'b0;
      // [RQ15] [RQ16] region index
      rg = bbc_region(link.addr);
      rd = 32'h0;
      s_nxt = s_r;
      s_nxt.mem_start = 1'b0;
      if (s_r.gap != 2'h0)
         s_nxt.gap = s_r.gap - 2'h1;
      // [RQ21] descriptor read skips gap
      if (dma_desc_read)
         s_nxt.gap = 2'h0;
      unique case (s_r.st)
         BBC_IDLE:
         begin
            if (link.req && s_r.booted &&
                link.addr[31:BBC_BLK_LSB] == BBC_WIDTH_ADDR[31:BBC_BLK_LSB])
            begin
               unique case (link.addr)
                  BBC_WIDTH_ADDR: rd = s_r.width;
                  BBC_TURN_ADDR: rd = s_r.turn;
                  BBC_FAULT_ADDR: rd = s_r.fault;
                  BBC_CTRL_ADDR: rd = {29'h0, s_r.ctrl};
                  BBC_CPU_LIM_ADDR: rd = {16'h0, s_r.cpu_lim};
                  BBC_IP_LIM_ADDR: rd = {16'h0, s_r.ip_lim};
                  BBC_STAT_ADDR: rd = {29'h0, s_r.stat};
                  BBC_WDOG_ADDR: rd = 32'(s_r.wd_cnt);
                  default: rd = 32'h0;
               endcase
               if (link.wr)
               begin
                  // [RQ20] fault address has no write path
                  unique case (link.addr)
                     // [RQ13] width programming
                     BBC_WIDTH_ADDR: s_nxt.width = {2'h0, link.wdata[29:0]};
                     BBC_TURN_ADDR: s_nxt.turn = {2'h0, link.wdata[29:0]};
                     // [RQ4] software disable path
                     BBC_CTRL_ADDR: s_nxt.ctrl = link.wdata[2:0];
                     BBC_CPU_LIM_ADDR: s_nxt.cpu_lim = link.wdata[15:0];
                     BBC_IP_LIM_ADDR: s_nxt.ip_lim = link.wdata[15:0];
                     BBC_STAT_ADDR: s_nxt.stat = s_r.stat & ~link.wdata[2:0];
                     BBC_WDOG_ADDR:
                     begin
                        s_nxt.wd_cnt = link.wdata[WDOG_BITS-1:0];
                        wd_wr = 1'b1;
                     end
                     default: ;
                  endcase
               end
               s_nxt.rdata = rd;
               s_nxt.ack = 1'b1;
               s_nxt.st = BBC_RESP;
            end
            // [RQ18] no start while gap runs
            else if (link.req && s_r.booted && s_r.gap == 2'h0)
            begin
               s_nxt.mem_start = 1'b1;
               s_nxt.mem_addr = link.addr;
               s_nxt.mem_write = link.wr;
               s_nxt.mem_wdata = link.wdata;
               s_nxt.mem_width = s_r.width[2*rg +: 2];
               s_nxt.mem_turn = s_r.turn[2*rg +: 2];
               // [RQ23] clear at transfer start
               s_nxt.cpu_cnt = 16'h0;
               s_nxt.st = BBC_MEM;
            end
         end
         BBC_MEM:
         begin
            if (mem_ack)
            begin
               s_nxt.ack = 1'b1;
               s_nxt.rdata = mem_rdata;
               // [RQ18] load gap after read
               if (!s_r.mem_write)
                  s_nxt.gap = s_r.mem_turn;
               s_nxt.st = BBC_RESP;
            end
            // [RQ7] [RQ23] compare against limit
            else if (s_r.ctrl[BBC_CTRL_CPU_EN] && s_r.cpu_cnt == s_r.cpu_lim)
            begin
               // [RQ8] error with ack
               s_nxt.ack = 1'b1;
               s_nxt.berr = 1'b1;
               s_nxt.rdata = 32'h0;
               // [RQ9] capture fault address
               s_nxt.fault = s_r.mem_addr;
               // [RQ10] both status bits set
               s_nxt.stat[BBC_STAT_CPU] = 1'b1;
               s_nxt.stat[BBC_STAT_IP] = 1'b1;
               s_nxt.st = BBC_RESP;
            end
            // wait states from memory are counted too
            else
               s_nxt.cpu_cnt = s_r.cpu_cnt + 16'h1;
         end
         BBC_RESP:
         begin
            s_nxt.ack = 1'b0;
            s_nxt.berr = 1'b0;
            s_nxt.st = BBC_IDLE;
         end
      endcase
      // [RQ11] peripheral hold timer, independent
      if (ip_hold && s_r.ctrl[BBC_CTRL_IP_EN])
      begin
         if (s_r.ip_cnt == s_r.ip_lim)
            s_nxt.stat[BBC_STAT_IP] = 1'b1;
         else
            s_nxt.ip_cnt = s_r.ip_cnt + 16'h1;
      end
      else
         s_nxt.ip_cnt = 16'h0;
      // [RQ1] warm reset pulse
      if (s_r.warm_cnt != 3'h0)
      begin
         s_nxt.warm_cnt = s_r.warm_cnt - 3'h1;
         s_nxt.warm_b = (s_r.warm_cnt == 3'h1);
      end
      else if (s_r.ctrl[BBC_CTRL_WDOG_EN] && !wd_wr)
      begin
         if (&s_r.wd_cnt)
         begin
            s_nxt.wd_cnt = '0;
            s_nxt.warm_cnt = BBC_WARM_CYC;
            s_nxt.warm_b = 1'b0;
            // [RQ5] watchdog cause, set wins over clear
            s_nxt.stat[BBC_STAT_WDOG] = 1'b1;
         end
         else
            s_nxt.wd_cnt = s_r.wd_cnt + 1'b1;
      end
      // straps are caught once after cold reset only
      if (!s_r.booted)
      begin
         s_nxt.booted = 1'b1;
         // [RQ2] [RQ13] boot width into every region
         s_nxt.width = {2'h0, {BBC_NREG{boot_width}}};
         // [RQ4] [RQ6] enables follow boot mode
         s_nxt.ctrl = host_boot ? 3'h0 : BBC_CTRL_ALL;
      end
      s_nxt.irq = s_nxt.stat[BBC_STAT_CPU] | s_nxt.stat[BBC_STAT_IP];
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s_r <= '0;
         s_r.st <= BBC_IDLE;
         s_r.warm_b <= 1'b1;
         // [RQ17] three turnaround clocks everywhere
         s_r.turn <= {2'h0, BBC_TURN_RST};
         s_r.cpu_lim <= BBC_LIM_RST;
         s_r.ip_lim <= BBC_LIM_RST;
      end
      else
         s_r <= s_nxt;
   end

   assign link.ack = s_r.ack;
   assign link.berr = s_r.berr;
   assign link.rdata = s_r.rdata;
   assign link.warm_rst_b = s_r.warm_b;
   assign mem_start = s_r.mem_start;
   assign mem_addr = s_r.mem_addr;
   assign mem_write = s_r.mem_write;
   assign mem_wdata = s_r.mem_wdata;
   assign mem_width = s_r.mem_width;
   assign bus_irq = s_r.irq;
endmodule : bbc_dev

/* File: bbc_link_chk.sv */
// timing checks on the core-to-device link
// assumes one clock domain and the cold reset rst_b, active low
module bbc_link_chk
   import bbc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // link signals
   input wire logic req,
   input wire logic wr,
   input wire logic [31:0] addr,
   input wire logic [31:0] wdata,
   input wire logic [31:0] rdata,
   input wire logic ack,
   input wire logic berr,
   input wire logic warm_rst_b
);
   timeunit 1ns;
   timeprecision 1ps;
   logic in_blk;
   // register block decode
   assign in_blk = addr[31:BBC_BLK_LSB] == BBC_WIDTH_ADDR[31:BBC_BLK_LSB];
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   property p_berr_ack;
      berr |-> ack && !in_blk;
   endproperty
   a_berr_ack: assert property (p_berr_ack) else $error("berr without ack");
   property p_ack_pulse;
      ack |=> !ack && !berr;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_reg_ack;
      req && in_blk && !$past(req) |-> ##[1:2] ack;
   endproperty
   a_reg_ack: assert property (p_reg_ack) else $error("register access not answered");
   property p_mem_ack;
      req && !in_blk && !$past(req) |-> ##[1:200] ack;
   endproperty
   a_mem_ack: assert property (p_mem_ack) else $error("memory access never ended");
   property p_wdog_low;
      $fell(warm_rst_b) |-> !warm_rst_b [*4] ##1 warm_rst_b;
   endproperty
   a_wdog_low: assert property (p_wdog_low) else $error("warm reset pulse length");
   property p_wdog_gap;
      $rose(warm_rst_b) |-> warm_rst_b [*8];
   endproperty
   a_wdog_gap: assert property (p_wdog_gap) else $error("warm reset repeated");
   property p_req_hold;
      req && !ack |=> !warm_rst_b || (req && $stable(addr) && $stable(wr));
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("request dropped early");
   property p_rdata_hold;
      !ack |-> $stable(rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
endmodule : bbc_link_chk

/* File: bbc_link_if.sv */
// link between the core bus interface and the bus-control device
// assumes the testbench supplies clk and the cold reset
interface bbc_link_if
(
   input logic clk,
   input logic rst_b
);
   logic req;
   logic wr;
   logic [31:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic ack;
   logic berr;
   logic warm_rst_b;

   modport dev
   (
      input req, wr, addr, wdata,
      output rdata, ack, berr, warm_rst_b
   );
   modport core
   (
      output req, wr, addr, wdata,
      input rdata, ack, berr, warm_rst_b
   );
endinterface : bbc_link_if

/* File: bbc_pkg.sv */
// constants and types shared by both ends of the bus-control link
// assumes a single 100 MHz clock and physical addresses on the link
package bbc_pkg;
   // register block, byte addresses
   localparam logic [31:0] BBC_WIDTH_ADDR = 32'hffffe200;
   localparam logic [31:0] BBC_TURN_ADDR = 32'hffffe204;
   localparam logic [31:0] BBC_FAULT_ADDR = 32'hffffe208;
   localparam logic [31:0] BBC_CTRL_ADDR = 32'hffffe20c;
   localparam logic [31:0] BBC_CPU_LIM_ADDR = 32'hffffe210;
   localparam logic [31:0] BBC_IP_LIM_ADDR = 32'hffffe214;
   localparam logic [31:0] BBC_STAT_ADDR = 32'hffffe218;
   localparam logic [31:0] BBC_WDOG_ADDR = 32'hffffe21c;
   localparam int BBC_BLK_LSB = 5;
   // control bits
   localparam int BBC_CTRL_WDOG_EN = 0;
   localparam int BBC_CTRL_CPU_EN = 1;
   localparam int BBC_CTRL_IP_EN = 2;
   // status bits, write one to clear
   localparam int BBC_STAT_WDOG = 0;
   localparam int BBC_STAT_CPU = 1;
   localparam int BBC_STAT_IP = 2;
   // port width codes
   typedef logic [1:0] bbc_width_t;
   localparam bbc_width_t BBC_W8 = 2'h0;
   localparam bbc_width_t BBC_W16 = 2'h1;
   localparam bbc_width_t BBC_W32 = 2'h2;
   // regions: eight 64MB kernel direct sub-regions, then seven 512MB
   localparam int BBC_NREG = 15;
   localparam logic [3:0] BBC_KREGIONS = 4'h8;
   localparam logic [29:0] BBC_TURN_RST = 30'h3fffffff;
   localparam logic [15:0] BBC_LIM_RST = 16'hffff;
   localparam logic [2:0] BBC_CTRL_ALL = 3'h7;
   // timing
   localparam int BBC_CLK_NS = 10;
   localparam int BBC_WARM_NS = 40;
   localparam logic [2:0] BBC_WARM_CYC = 3'((BBC_WARM_NS + BBC_CLK_NS - 1) / BBC_CLK_NS);
   localparam int BBC_WDOG_BITS = 32;
   localparam int BBC_KICK_NS = 10000;
   localparam logic [15:0] BBC_KICK_CYC = 16'(BBC_KICK_NS / BBC_CLK_NS);
   // core boot programming, both boot modes
   localparam logic [31:0] BBC_BOOT_WIDTHS = 32'h2aaaaaaa;
   localparam logic [31:0] BBC_BOOT_TURNS = 32'h15555555;
   localparam logic [15:0] BBC_BOOT_CPU_LIM = 16'h0040;

   function automatic logic [3:0] bbc_region(input logic [31:0] a);
      if (a[31:29] == 3'h0)
         return {1'b0, a[28:26]};
      return BBC_KREGIONS + {1'b0, a[31:29]} - 4'h1;
   endfunction : bbc_region
endpackage : bbc_pkg

/* File: bbc_tb.sv */
// self-checking bench: core and device joined by the link
// assumes package, interface and checker files compiled first
module bbc_tb
   import bbc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_b, cmd_valid, cmd_write, cmd_ready, res_valid, res_err, err;
   logic [31:0] cmd_addr, cmd_wdata, res_data, mem_addr, mem_wdata, mem_rdata, rd, a, wd_seen;
   logic mem_start, mem_write, mem_ack, ip_hold, dma_desc_read, host_boot, bus_irq;
   bbc_width_t boot_width, mem_width, w_seen;
   int error_cnt, checks_done, cyc, rd_ack_cyc, start_cyc, berr_cyc, low_cnt, gap;
   bbc_link_if link (.clk(clk), .rst_b(rst_b));
   bbc_dev i_bbc_dev (.clk(clk), .rst_b(rst_b), .link(link), .boot_width(boot_width),
      .host_boot(host_boot), .mem_start(mem_start), .mem_addr(mem_addr),
      .mem_write(mem_write), .mem_wdata(mem_wdata), .mem_width(mem_width),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata), .dma_desc_read(dma_desc_read),
      .ip_hold(ip_hold), .bus_irq(bus_irq));
   bbc_core i_bbc_core (.clk(clk), .rst_b(rst_b), .link(link), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
      .cmd_ready(cmd_ready), .res_valid(res_valid), .res_data(res_data),
      .res_err(res_err));
   bbc_link_chk i_bbc_link_chk (.clk(clk), .rst_b(rst_b), .req(link.req), .wr(link.wr),
      .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack),
      .berr(link.berr), .warm_rst_b(link.warm_rst_b));
   // memory answers with data that differs per address
   assign mem_rdata = ~mem_addr;

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // negedge sampling, away from the launching edge
   always @(negedge clk)
   begin
      cyc++;
      if (!link.warm_rst_b)
         low_cnt++;
      if (mem_start)
      begin
         w_seen = mem_width;
         wd_seen = mem_wdata;
         start_cyc = cyc;
         if (!mem_write)
            gap = cyc - rd_ack_cyc;
      end
      if (link.ack && !link.wr && link.addr[31:16] != 16'hffff)
         rd_ack_cyc = cyc;
      if (link.berr)
         berr_cyc = cyc;
   end

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic finish_test();
      if (error_cnt == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : finish_test

   function automatic logic lvl(input int s);
      return s == 0 ? cmd_ready : (s == 1 ? res_valid : link.warm_rst_b);
   endfunction : lvl

   // bounded wait; a hang counts as a mismatch
   task automatic wait_lvl(input int s, input logic v, input int n);
      for (int i = 0; i < n && lvl(s) !== v; i++)
         @(negedge clk);
      if (lvl(s) !== v)
      begin
         chk("wait", 32'h0, 32'h1);
         finish_test();
      end
   endtask : wait_lvl

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step

   // one user command, held until taken, then its result
   task automatic acc(input logic w, input logic [31:0] ad, input logic [31:0] d);
      step(1);
      cmd_valid = 1'b1;
      cmd_write = w;
      cmd_addr = ad;
      cmd_wdata = d;
      @(negedge clk);
      wait_lvl(0, 1'b1, 3000);
      step(1);
      cmd_valid = 1'b0;
      wait_lvl(1, 1'b1, 3000);
      rd = res_data;
      err = res_err;
   endtask : acc

   initial
   begin
      rst_b = 1'b0;
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_addr = 32'h0;
      cmd_wdata = 32'h0;
      mem_ack = 1'b1;
      ip_hold = 1'b0;
      dma_desc_read = 1'b0;
      host_boot = 1'b0;
      boot_width = BBC_W8;
      step(10);
      rst_b = 1'b1;
      acc(1'b0, BBC_WIDTH_ADDR, 32'h0);
      chk("boot widths", rd, BBC_BOOT_WIDTHS);
      acc(1'b0, BBC_TURN_ADDR, 32'h0);
      chk("boot turns", rd, BBC_BOOT_TURNS);
      chk("turn field", 32'(rd[29:28]), 32'h1);
      acc(1'b0, BBC_IP_LIM_ADDR, 32'h0);
      chk("ip limit", rd, 32'(BBC_BOOT_CPU_LIM) + 32'h1);
      acc(1'b0, BBC_CTRL_ADDR, 32'h0);
      chk("ctrl", rd, 32'h7);
      // per-region widths; top region keeps 32-bit for the register block
      a = 32'h0;
      for (int i = 0; i < BBC_NREG; i++)
         a[2*i+:2] = 2'(i % 3);
      acc(1'b1, BBC_WIDTH_ADDR, a);
      for (int i = 0; i < BBC_NREG; i++)
      begin
         a = (i < 8) ? {3'h0, 3'(i), 26'h40} : {3'(i - 7), 29'h40};
         acc(1'b0, a, 32'h0);
         chk("region width", 32'(w_seen), 32'(i % 3));
         chk("read data", rd, ~a);
      end
      // memory write into region 1, width code 1
      acc(1'b1, 32'h04000300, 32'h12345678);
      chk("write width", 32'(w_seen), 32'h1);
      chk("write data", wd_seen, 32'h12345678);
      // back-to-back reads after turnaround settings 1 to 3
      for (int t = 1; t < 4; t++)
      begin
         acc(1'b1, BBC_TURN_ADDR, {2'h0, {15{2'(t)}}});
         acc(1'b0, 32'h100, 32'h0);
         acc(1'b0, 32'h104, 32'h0);
         chk("turn gap", 32'(gap > t), 32'h1);
      end
      // stalled memory read ends by time-out
      step(1);
      mem_ack = 1'b0;
      acc(1'b0, 32'h20000010, 32'h0);
      chk("timeout err", 32'(err), 32'h1);
      chk("timeout cycles", 32'(berr_cyc - start_cyc), 32'(BBC_BOOT_CPU_LIM) + 1);
      chk("irq", 32'(bus_irq), 32'h1);
      mem_ack = 1'b1;
      acc(1'b0, BBC_FAULT_ADDR, 32'h0);
      chk("fault addr", rd, 32'h20000010);
      acc(1'b1, BBC_FAULT_ADDR, 32'h5a5a5a5a);
      acc(1'b0, BBC_FAULT_ADDR, 32'h0);
      chk("fault ro", rd, 32'h20000010);
      acc(1'b0, BBC_STAT_ADDR, 32'h0);
      chk("status", rd, 32'h6);
      acc(1'b1, BBC_STAT_ADDR, 32'h6);
      acc(1'b0, BBC_STAT_ADDR, 32'h0);
      chk("status clr", rd, 32'h0);
      chk("irq clr", 32'(bus_irq), 32'h0);
      // peripheral hold below and above its limit
      for (int k = 60; k < 100; k += 12)
      begin
         step(1);
         ip_hold = 1'b1;
         step(k);
         ip_hold = 1'b0;
         acc(1'b0, BBC_STAT_ADDR, 32'h0);
         chk("ip status", rd, (k > BBC_BOOT_CPU_LIM + 1) ? 32'h4 : 32'h0);
         acc(1'b1, BBC_STAT_ADDR, 32'h4);
      end
      // two kick periods pass; count must stay within one period plus 16
      step(2000);
      acc(1'b0, BBC_WDOG_ADDR, 32'h0);
      chk("wdog kicked", 32'(rd <= 32'(BBC_KICK_CYC) + 32'h10), 32'h1);
      // watchdog rollover, then disabled
      // loaded next to rollover so no kick can slip in first
      low_cnt = 0;
      acc(1'b1, BBC_WDOG_ADDR, 32'hfffffffe);
      wait_lvl(2, 1'b0, 200);
      wait_lvl(2, 1'b1, 20);
      chk("warm pulse", 32'(low_cnt), 32'h4);
      acc(1'b0, BBC_STAT_ADDR, 32'h0);
      chk("wdog status", 32'(rd[BBC_STAT_WDOG]), 32'h1);
      acc(1'b1, BBC_CTRL_ADDR, 32'h6);
      low_cnt = 0;
      acc(1'b1, BBC_WDOG_ADDR, 32'hfffffffe);
      step(150);
      chk("wdog off", 32'(low_cnt), 32'h0);
      finish_test();
   end
endmodule : bbc_tb
